// File: dv/sms_peer.sv
/* Far-side serial slave: idle-low clock, first-edge sampling, MSB first.
 Assumes the bench resolves the pins and frames each word with select. */
`timescale 1ns/100ps
`default_nettype none
module sms_peer
(
   // Pins
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_ss_n,
   output logic o_miso,
   // Word to return, bits received
   input wire logic [7:0] i_tx,
   output logic [7:0] o_rx
);
logic [7:0] sh;
////////////////////
// loaded, first bit out before the first edge
always @(negedge i_ss_n)
begin
   sh = i_tx;
   o_miso = i_tx[7];
end
// same idle level and phase as the master
always @(posedge i_sck)
   if (!i_ss_n)
      o_rx = {o_rx[6:0], i_mosi};
always @(negedge i_sck)
   if (!i_ss_n)
   begin
      sh = {sh[6:0], 1'b0};
      o_miso = sh[7];
   end
// Released line shows no stale level
always @(posedge i_ss_n)
   o_miso = ~o_miso;
endmodule // sms_peer
`default_nettype wire

// File: dv/sms_shifter_bench.sv
/* Self-checking bench for sms_shifter with a serial slave model.
 Assumes src/ on the include path and the checker bound in. */
`timescale 1ns/100ps
`default_nettype none
module sms_shifter_bench;
typedef struct {logic [7:0] stat, hi, lo, ptx, prx, dlo, dhi;} sms_row_t;
logic i_clock, i_arst_n, cyc, stb, we, ss_n, msck, mmosi;
logic [3:0] adr;
logic [7:0] ptx, mrx;
logic [31:0] wdat, rd;
int mismatches, tests_run, cycles;
wire [31:0] rdat;
wire [7:0] peer_rx;
wire ack, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, peer_miso, req;
wire sck_w = sck_oe_n ? msck : sck;
wire mosi_w = mosi_oe_n ? mmosi : mosi;
wire miso_w = miso_oe_n ? peer_miso : miso;
sms_row_t rows [3] = '{'{8'h00, 8'h00, 8'hA5, 8'h3C, 8'hA5, 8'h3C, 8'h00},
   '{8'h04, 8'h00, 8'h01, 8'h03, 8'h80, 8'hC0, 8'h00}, '{8'h02, 8'h12, 8'h34, 8'h5A, 8'h34, 8'h00, 8'h5A}};
sms_shifter i_sms_shifter (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
   .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sck(sck_w), .o_sck(sck),
   .o_sck_oe_n(sck_oe_n), .i_mosi(mosi_w), .o_mosi(mosi), .o_mosi_oe_n(mosi_oe_n), .i_miso(miso_w), .o_miso(miso),
   .o_miso_oe_n(miso_oe_n), .i_ss_n(ss_n), .o_transfer_done_req(req));
sms_peer i_sms_peer (.i_sck(sck_w), .i_mosi(mosi_w), .i_ss_n(ss_n), .o_miso(peer_miso), .i_tx(ptx), .o_rx(peer_rx));
////////////////////
task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
   tests_run++;
   if (seen !== exp)
   begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
   end
endtask
task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
   @(posedge i_clock);
   cyc <= 1'b1;
   stb <= 1'b1;
   we <= w;
   adr <= a;
   wdat <= {24'h0, d};
   @(posedge i_clock);
   while (ack !== 1'b1)
      @(posedge i_clock);
   rd = rdat;
   cyc <= 1'b0;
   stb <= 1'b0;
endtask
// bench master, phase 1: drive on the rising edge, sample on the falling one
task mxfer(input logic [7:0] d);
   for (int i = 7; i >= 0; i--)
   begin
      msck <= 1'b1;
      mmosi <= d[i];
      repeat (8) @(posedge i_clock);
      msck <= 1'b0;
      mrx = {mrx[6:0], miso_w};
      repeat (8) @(posedge i_clock);
   end
endtask
task wait_done;
   repeat (400)
      if (req !== 1'b1)
         @(posedge i_clock);
   chk("done", {31'h0, req}, 32'h1);
endtask
task test_done;
   $display("checks %0d mismatches %0d", tests_run, mismatches);
   if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
   else
      $display("TB: FAIL");
   $finish;
endtask
////////////////////
initial
begin
   i_clock = 1'b0;
   forever #12.5 i_clock = ~i_clock;
end
always @(posedge i_clock)
begin
   cycles <= cycles + 1;
   if (cycles == 8000)
   begin
      mismatches++;
      test_done();
   end
end
initial
begin
   {cyc, stb, we, adr, wdat, ptx, i_arst_n, ss_n, msck, mmosi} = '0;
   ss_n = 1'b1;
   mismatches = 0;
   tests_run = 0;
   cycles = 0;
   repeat (16) @(posedge i_clock);
   i_arst_n <= 1'b1;
   wb(1'b0, 4'h0, 8'h00);
   chk("ctrl", rd, 32'h0);
   wb(1'b0, 4'h4, 8'h00);
   chk("stat", rd, 32'h0);
   wb(1'b0, 4'h2, 8'h00);
   chk("unmapped", rd, 32'h0);
   // Enabled master with done request, divider code 4
   wb(1'b1, 4'h0, 8'hE4);
   foreach (rows[k])
   begin
      ptx <= rows[k].ptx;
      wb(1'b1, 4'h4, rows[k].stat);
      ss_n <= 1'b0;
      if (rows[k].stat[1])
         wb(1'b1, 4'hC, rows[k].hi);
      wb(1'b1, 4'h8, rows[k].lo);
      wait_done();
      chk("peer rx", {24'h0, peer_rx}, {24'h0, rows[k].prx});
      wb(1'b0, 4'h8, 8'h00);
      chk("rx low", rd, {24'h0, rows[k].dlo});
      wb(1'b0, 4'hC, 8'h00);
      chk("rx high", rd, {24'h0, rows[k].dhi});
      ss_n <= 1'b1;
   end
   // Second write lands mid-word and must be turned away
   wb(1'b1, 4'h4, 8'h00);
   ss_n <= 1'b0;
   wb(1'b1, 4'h8, 8'h81);
   wb(1'b1, 4'h8, 8'hFF);
   wb(1'b0, 4'h4, 8'h00);
   chk("collision", rd, 32'h40);
   wait_done();
   chk("word kept", {24'h0, peer_rx}, 32'h81);
   wb(1'b0, 4'h4, 8'h00);
   chk("flags", rd, 32'hC0);
   wb(1'b1, 4'h4, 8'h00);
   wb(1'b0, 4'h4, 8'h00);
   chk("cleared", rd, 32'h0);
   ss_n <= 1'b1;
   wb(1'b1, 4'h0, 8'hB4);
   repeat (4) @(posedge i_clock);
   chk("sck idle", {31'h0, sck}, 32'h1);
   wb(1'b1, 4'h0, 8'h80);
   repeat (6) @(posedge i_clock);
   chk("deselected", {31'h0, miso_oe_n}, 32'h1);
   ss_n <= 1'b0;
   repeat (6) @(posedge i_clock);
   chk("selected", {31'h0, miso_oe_n}, 32'h0);
   chk("unloaded", {31'h0, miso}, 32'h0);
   // Slave with done request, idle-low clock, phase 1
   wb(1'b1, 4'h0, 8'hC8);
   wb(1'b1, 4'h8, 8'hC3);
   mxfer(8'h96);
   wb(1'b0, 4'h4, 8'h00);
   chk("slave done", rd, 32'h80);
   chk("slave tx", {24'h0, mrx}, 32'hC3);
   mxfer(8'h5A);
   wb(1'b0, 4'h8, 8'h00);
   chk("slave held", rd, 32'h96);
   wb(1'b1, 4'h4, 8'h00);
   mxfer(8'h3C);
   chk("slave zeros", {24'h0, mrx}, 32'h0);
   wb(1'b0, 4'h8, 8'h00);
   chk("slave rx", rd, 32'h3C);
   test_done();
end
endmodule // sms_shifter_bench
`default_nettype wire

// File: dv/sms_shifter_monitor.sv
/* Port checker for sms_shifter.
 Bound below; sees only the shifter's ports. */
`timescale 1ns/100ps
`default_nettype none
module sms_shifter_monitor
(
   // Clock, reset, bus
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   // Serial pins
   input wire logic i_ss_n,
   input wire logic o_sck,
   input wire logic o_sck_oe_n,
   input wire logic o_mosi_oe_n,
   input wire logic o_miso,
   input wire logic o_miso_oe_n,
   input wire logic o_transfer_done_req
);
default clocking @(posedge i_clock); endclocking
default disable iff (!i_arst_n);
////////////////////
// Clock edges per word; a control write may move the idle level, so it restarts the count
logic [5:0] edges;
logic sck_q;
always_ff @(posedge i_clock or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      sck_q <= 1'b0;
      edges <= 6'h00;
   end
   else
   begin
      sck_q <= o_sck;
      if (o_transfer_done_req || (i_wb_cyc && i_wb_we && i_wb_adr == 4'h0))
         edges <= 6'h00;
      else if (!o_sck_oe_n && o_sck != sck_q)
         edges <= edges + 6'h01;
   end
end
////////////////////
unsel_miso_a: assert property (i_ss_n [*5] |-> o_miso_oe_n)
   else $error("driven while deselected");
unsel_quiet_a: assert property ((o_sck_oe_n && i_ss_n && !i_wb_cyc) [*5] |-> $stable(o_miso))
   else $error("deselected slave shifted");
// The last clock edge and the done flag land together, so that edge is not yet in the count
word_edges_a: assert property ($rose(o_transfer_done_req) && !o_sck_oe_n |-> (edges + {5'h00, o_sck != sck_q}) == 6'h10 || (edges + {5'h00, o_sck != sck_q}) == 6'h20)
   else $error("wrong clock edge count");
role_mosi_a: assert property (o_sck_oe_n |-> o_mosi_oe_n)
   else $error("slave drives data-out");
role_miso_a: assert property (!o_sck_oe_n |-> o_miso_oe_n)
   else $error("master drives data-in");
ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
   else $error("ack too long");
ack_next_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
   else $error("ack late");
unmapped_zero_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr[1:0] != 2'b00 |-> o_wb_dat == 32'h0)
   else $error("unmapped read not zero");
endmodule // sms_shifter_monitor
bind sms_shifter sms_shifter_monitor i_sms_shifter_monitor (.i_clock(i_clock), .i_arst_n(i_arst_n),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
   .o_wb_ack(o_wb_ack), .i_ss_n(i_ss_n), .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n), .o_mosi_oe_n(o_mosi_oe_n),
   .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n), .o_transfer_done_req(o_transfer_done_req));
`default_nettype wire

// File: src/sms_map.vh
/*
 Register offsets, field positions and reset values of the serial shifter.
 Assumes a 32-bit classic Wishbone slave decoding byte addresses [3:0].
*/
`ifndef SMS_MAP_VH
`define SMS_MAP_VH

// Register byte offsets
`define SMS_ADR_CTRL 4'h0
`define SMS_ADR_STAT 4'h4
`define SMS_ADR_DLO 4'h8
`define SMS_ADR_DHI 4'hC

// serial_control_reg fields
`define SMS_CTRL_EN 7
`define SMS_CTRL_IE 6
`define SMS_CTRL_MST 5
`define SMS_CTRL_CLOCK_IDLE_LEVEL 4
`define SMS_CTRL_CLOCK_SAMPLE_EDGE 3
`define SMS_CTRL_DIV_HI 2
`define SMS_CTRL_DIV_LO 0

// serial_status_reg fields
`define SMS_STAT_DONE 7
`define SMS_STAT_WRITE_COLLISION_FLAG 6
`define SMS_STAT_ORDER 2
`define SMS_STAT_WIDE 1

// Reset values
`define SMS_CTRL_RST 8'h00
`define SMS_DATA_RST 16'h0000
`define SMS_PIN_RST 4'h8

// Bits per word
`define SMS_BITS_NARROW 5'h08
`define SMS_BITS_WIDE 5'h10

`endif

// File: src/sms_shifter.v
/*
 Four-wire serial shifter, master or slave, with a classic Wishbone
 register port (32-bit data, byte lane 0 only).
 Assumes pin inputs are asynchronous to i_clock; pad logic resolves the
 wires from the active-low output enables.
*/
// Notes on behaviour
// - Unselected slave leaves its data-out pin undriven.
// - A byte takes eight clock periods.
// - Unselected slave ignores the serial clock.
// - master_select chooses master or slave role.
// - Low and high data addresses: write transmit, read receive.
// - Wide words: high byte first, low starts.
// - Idle master starts shifting at once on write.
// - Write while busy flags collision, data kept.
// - Finished word sets done flag, optional request.
// - Receive order follows bit_order_select.
// - Slave counts clock edges, done after word.
// - Slave holds received word while done set.
// - Unloaded slave shifts out zeros.
// - Idle level and sample edge are selectable.
// - Phase 0 samples on first clock edge.
// - Phase 1 shifts first edge, samples second.
// - Both ends use identical polarity and phase.
// - Collision raises no request, stays until cleared.
// - Idle clock low or high per setting.
// - Divider code selects rate fsys over power.
// - Order bit zero sends most significant first.
// - Width bit selects 8 or 16 bits.
`include "sms_map.vh"
`timescale 1ns/100ps
`default_nettype none

module sms_shifter
(
   // Clock and reset
   input wire i_clock,
   input wire i_arst_n,
   // Wishbone slave
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [3:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   // Serial clock pin
   input wire i_sck,
   output wire o_sck,
   output wire o_sck_oe_n,
   // Master-out data pin
   input wire i_mosi,
   output wire o_mosi,
   output wire o_mosi_oe_n,
   // Master-in data pin
   input wire i_miso,
   output wire o_miso,
   output wire o_miso_oe_n,
   // Slave select, active low
   input wire i_ss_n,
   // Done request
   output wire o_transfer_done_req
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers

wire [3:0] pin_raw = {i_ss_n, i_miso, i_mosi, i_sck};
wire [3:0] pin_f;
localparam [3:0] PIN_RST = `SMS_PIN_RST;

genvar g;
generate
   for (g = 0; g < 4; g = g + 1)
   begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg f;
      // A change counts only once the last two stages agree
      always @(posedge i_clock or negedge i_arst_n)
      begin
         if (!i_arst_n)
         begin
            s1 <= PIN_RST[g];
            s2 <= PIN_RST[g];
            s3 <= PIN_RST[g];
            f <= PIN_RST[g];
         end
         else
         begin
            s1 <= pin_raw[g];
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
               f <= s3;
         end
      end
      assign pin_f[g] = f;
   end
endgenerate

wire sck_f = pin_f[0];
wire mosi_f = pin_f[1];
wire miso_f = pin_f[2];
wire ss_n_f = pin_f[3];

////////////////////////////////////////////////////////////////////////
// Registers and decode

reg [7:0] ctrl;
reg order;
reg wide;
reg done_f;
reg write_collision_flag_f;
reg [7:0] hi_hold;
reg [15:0] tx_sr;
reg [15:0] rx_sr;
reg tx_full;
reg started;
reg [4:0] bcnt;
reg m_busy;
reg [6:0] hc;
reg [5:0] ecnt;
reg sck_r;
reg sck_prev;

wire en = ctrl[`SMS_CTRL_EN];
wire ie = ctrl[`SMS_CTRL_IE];
wire mst = ctrl[`SMS_CTRL_MST];
wire clock_idle_level = ctrl[`SMS_CTRL_CLOCK_IDLE_LEVEL];
wire clock_sample_edge = ctrl[`SMS_CTRL_CLOCK_SAMPLE_EDGE];
wire [2:0] div = ctrl[`SMS_CTRL_DIV_HI:`SMS_CTRL_DIV_LO];

wire req = i_wb_cyc & i_wb_stb;
// Writes take effect on the edge that sees ack high
wire wr = req & i_wb_we & o_wb_ack & i_wb_sel[0];
wire wr_ctrl = wr && (i_wb_adr == `SMS_ADR_CTRL);
wire wr_stat = wr && (i_wb_adr == `SMS_ADR_STAT);
wire wr_lo = wr && (i_wb_adr == `SMS_ADR_DLO);
wire wr_hi = wr && (i_wb_adr == `SMS_ADR_DHI);
wire [7:0] wdat = i_wb_dat[7:0];

wire [4:0] nbits = wide ? `SMS_BITS_WIDE : `SMS_BITS_NARROW;
wire [5:0] elast = {nbits, 1'b0} - 6'h01;

wire head = order ? tx_sr[0] : (wide ? tx_sr[15] : tx_sr[7]);

////////////////////////////////////////////////////////////////////////
// Edge generation and detection

// half period of 2^(code-1), code 0 clamps to one cycle
wire [6:0] half_m1 = (div == 3'h0) ? 7'h00 : ((7'h01 << (div - 3'h1)) - 7'h01);

wire m_edge = m_busy && (hc == half_m1);
wire m_lead = m_edge && !ecnt[0];
wire m_trail = m_edge && ecnt[0];
wire m_last = m_edge && (ecnt == elast);

// unselected slave sees no clock; nor while done is set
wire s_act = en && !mst && !ss_n_f && !done_f;
wire s_chg = s_act && (sck_f != sck_prev);
// leading edge leaves the idle level
wire s_lead = s_chg && (sck_f != clock_idle_level);
wire s_trail = s_chg && (sck_f == clock_idle_level);

wire lead = mst ? m_lead : s_lead;
wire trail = mst ? m_trail : s_trail;
// phase 0 samples leading, phase 1 samples trailing
wire sample = clock_sample_edge ? trail : lead;
// first leading edge only starts the word in phase 1
wire shift_ev = clock_sample_edge ? (lead && started) : trail;
wire din = mst ? miso_f : mosi_f;

// slave done after the word's last sample
wire s_last = sample && !mst && (bcnt == (nbits - 5'h01));
wire fin = m_last || s_last;

wire busy_any = tx_full || started || (bcnt != 5'h00);
// write while data is held is a collision
wire collide = wr_lo && busy_any;
wire load_ok = wr_lo && !busy_any && en;

////////////////////////////////////////////////////////////////////////
// Bus slave

always @(posedge i_clock or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
   end
   else
   begin
      // Read data is latched at the taking edge and stands with ack
      o_wb_ack <= req & ~o_wb_ack;
      if (req & ~o_wb_ack)
      begin
         // data address reads the receive register
         case (i_wb_adr)
            `SMS_ADR_CTRL: o_wb_dat <= {24'h000000, ctrl};
            `SMS_ADR_STAT: o_wb_dat <= {24'h000000, done_f, write_collision_flag_f, 3'h0, order, wide, 1'b0};
            `SMS_ADR_DLO: o_wb_dat <= {24'h000000, rx_sr[7:0]};
            `SMS_ADR_DHI: o_wb_dat <= {24'h000000, wide ? rx_sr[15:8] : 8'h00};
            default: o_wb_dat <= 32'h00000000;
         endcase
      end
   end
end

always @(posedge i_clock or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      ctrl <= `SMS_CTRL_RST;
      order <= 1'b0;
      wide <= 1'b0;
      hi_hold <= 8'h00;
      done_f <= 1'b0;
      write_collision_flag_f <= 1'b0;
   end
   else
   begin
      if (wr_ctrl)
         ctrl <= wdat;
      if (wr_stat)
      begin
         order <= wdat[`SMS_STAT_ORDER];
         wide <= wdat[`SMS_STAT_WIDE];
      end
      // high byte is held until the low byte write
      if (wr_hi)
         hi_hold <= wdat;
      // set wins over a software clear (write zero)
      done_f <= fin | (done_f & ~(wr_stat & ~wdat[`SMS_STAT_DONE]));
      write_collision_flag_f <= collide | (write_collision_flag_f & ~(wr_stat & ~wdat[`SMS_STAT_WRITE_COLLISION_FLAG]));
   end
end

// request only while the request enable (ie) is set; collision never requests
assign o_transfer_done_req = done_f & ie;

////////////////////////////////////////////////////////////////////////
// Master clock generator

always @(posedge i_clock or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      m_busy <= 1'b0;
      hc <= 7'h00;
      ecnt <= 6'h00;
      sck_r <= 1'b0;
   end
   else if (!m_busy)
   begin
      // clock rests at the idle level
      sck_r <= clock_idle_level;
      hc <= 7'h00;
      ecnt <= 6'h00;
      // only a master drives transfers; start at once
      if (load_ok && mst)
         m_busy <= 1'b1;
   end
   else if (!en)
      m_busy <= 1'b0;
   else if (m_edge)
   begin
      hc <= 7'h00;
      sck_r <= ~sck_r;
      ecnt <= ecnt + 6'h01;
      // word ends after two edges per bit
      if (m_last)
         m_busy <= 1'b0;
   end
   else
      hc <= hc + 7'h01;
end

always @(posedge i_clock or negedge i_arst_n)
begin
   if (!i_arst_n)
      sck_prev <= 1'b0;
   else if (s_act)
      sck_prev <= sck_f;
   else
      sck_prev <= clock_idle_level;
end

////////////////////////////////////////////////////////////////////////
// Shift registers

always @(posedge i_clock or negedge i_arst_n)
begin
   if (!i_arst_n)
   begin
      tx_sr <= `SMS_DATA_RST;
      rx_sr <= `SMS_DATA_RST;
      tx_full <= 1'b0;
      started <= 1'b0;
      bcnt <= 5'h00;
   end
   else
   begin
      if (!en || (!mst && ss_n_f))
      begin
         // Deselect drops a partial word
         started <= 1'b0;
         bcnt <= 5'h00;
      end
      else if (fin)
      begin
         started <= 1'b0;
         bcnt <= 5'h00;
      end
      else
      begin
         if (lead)
            started <= 1'b1;
         if (sample)
            bcnt <= bcnt + 5'h01;
      end
      if (!en)
         tx_full <= 1'b0;
      else if (load_ok)
         tx_full <= 1'b1;
      else if (fin)
         tx_full <= 1'b0;
      // low byte write loads the whole word
      if (load_ok)
         tx_sr <= {wide ? hi_hold : 8'h00, wdat};
      // emptied register leaves zeros to send
      else if (fin)
         tx_sr <= 16'h0000;
      else if (shift_ev)
         tx_sr <= order ? {1'b0, tx_sr[15:1]} : {tx_sr[14:0], 1'b0};
      if (sample)
      begin
         if (order)
            rx_sr <= wide ? {din, rx_sr[15:1]} : {8'h00, din, rx_sr[7:1]};
         else
            rx_sr <= wide ? {rx_sr[14:0], din} : {8'h00, rx_sr[6:0], din};
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Pin drive

assign o_sck = sck_r;
assign o_sck_oe_n = ~(en & mst);
// Both data pins show the head bit; the enables pick the role
assign o_mosi = head;
assign o_mosi_oe_n = ~(en & mst);
assign o_miso = head;
// unselected slave releases the data-out pin
assign o_miso_oe_n = ~(en & ~mst & ~ss_n_f);

endmodule // sms_shifter

`default_nettype wire
